// ### pkg/esiu_pkg.sv
// extended stack instruction unit package: opcodes, widths, enums, carriers
// assumes a core with 12-bit data addresses and 21-bit program counter
package esiu_pkg;

	// ==========================================================
	// widths
	localparam int DADDR_W = 12;
	localparam int PC_W = 21;

	// ==========================================================
	// opcode fields: the e8-eb opcodes are the upper byte, the call is the whole word, the second word is the top nibble
	localparam logic [7:0] OP_PTR_ADD = 8'he8;
	localparam logic [7:0] OP_PTR_SUB = 8'he9;
	localparam logic [7:0] OP_PUSH_LIT = 8'hea;
	localparam logic [7:0] OP_IDX_MOVE = 8'heb;
	localparam logic [15:0] OP_CALL_WORKING_REGISTER = 16'h0014;
	localparam logic [3:0] OP_SECOND_WORD = 4'hf;
	localparam logic [1:0] SEL_STACK_PTR = 2'h3;
	localparam logic [PC_W-1:0] PC_RETURN_STEP = 21'h000002;
	localparam logic [7:0] INDIRECT_READ_VALUE = 8'h00;

	// indirect-access register addresses (low 12 bits); three pointers,
	// each with five access ports
	localparam logic [DADDR_W-1:0] INDF_BASE0 = 12'hfeb;
	localparam logic [DADDR_W-1:0] INDF_BASE1 = 12'hfe3;
	localparam logic [DADDR_W-1:0] INDF_BASE2 = 12'hfdb;
	localparam logic [2:0] INDF_SPAN = 3'h5;

	// ==========================================================
	// sequencer states
	typedef enum logic [1:0]
	{
		ESIU_IDLE = 2'b00,
		ESIU_RET = 2'b01,
		ESIU_CALL2 = 2'b10,
		ESIU_MOVE2 = 2'b11
	} esiu_state_e;

	// data memory request
	typedef struct packed
	{
		logic rd;
		logic wr;
		logic [DADDR_W-1:0] addr;
		logic [7:0] wdata;
	} esiu_mem_req_s;

	// pointer update request
	typedef struct packed
	{
		logic wr;
		logic [1:0] sel;
		logic [DADDR_W-1:0] value;
	} esiu_ptr_upd_s;

endpackage : esiu_pkg

// ### src/esiu_unit.sv
// extended stack instruction unit: decodes and sequences the extended group
// assumes one instruction word per cycle on instr_valid_i, phase q4 strobe
// from the core, and that the core stalls fetch while busy_o is high after a call or return
`timescale 1ns/1ps

module esiu_unit
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// configuration
	input wire logic extended_set_enable_cfg_i,
	// instruction stream
	input wire logic instr_valid_i,
	input wire logic [15:0] instr_i,
	input wire logic q4_i,
	// core state
	input wire logic [7:0] working_register_i,
	input wire logic [7:0] pc_high_latch_i,
	input wire logic [7:0] pc_upper_latch_i,
	input wire logic [esiu_pkg::PC_W-1:0] pc_i,
	input wire logic [esiu_pkg::DADDR_W-1:0] fsr0_i,
	input wire logic [esiu_pkg::DADDR_W-1:0] fsr1_i,
	input wire logic [esiu_pkg::DADDR_W-1:0] software_stack_pointer_i,
	input wire logic [7:0] mem_rdata_i,
	// results to core
	output esiu_pkg::esiu_mem_req_s mem_req_o,
	output esiu_pkg::esiu_ptr_upd_s ptr_upd_o,
	output logic pc_load_o,
	output logic [esiu_pkg::PC_W-1:0] pc_value_o,
	output logic stack_push_o,
	output logic [esiu_pkg::PC_W-1:0] stack_push_value_o,
	output logic return_o,
	output logic ext_hit_o,
	output logic busy_o
);
	import esiu_pkg::*;

	// ==========================================================
	// helpers
	// wrapping subtract gives a cheap range test per pointer
	function automatic logic is_indirect(input logic [DADDR_W-1:0] a);
		is_indirect = ((a - INDF_BASE0) < DADDR_W'(INDF_SPAN)) ||
			((a - INDF_BASE1) < DADDR_W'(INDF_SPAN)) ||
			((a - INDF_BASE2) < DADDR_W'(INDF_SPAN));
	endfunction : is_indirect

	function automatic logic [DADDR_W-1:0] sp_offset(
		input logic [DADDR_W-1:0] sp,
		input logic [6:0] off);
		sp_offset = sp + {5'h00, off};
	endfunction : sp_offset

	function automatic logic [DADDR_W-1:0] sel_ptr(input logic [1:0] s,
		input logic [DADDR_W-1:0] p0, input logic [DADDR_W-1:0] p1,
		input logic [DADDR_W-1:0] p2);
		unique case (s)
			2'h0: sel_ptr = p0;
			2'h1: sel_ptr = p1;
			default: sel_ptr = p2;
		endcase
	endfunction : sel_ptr

	// ==========================================================
	// decode
	logic enabled_q;
	logic [7:0] op_hi;
	logic [1:0] fsel;
	logic [DADDR_W-1:0] lit6;
	logic [DADDR_W-1:0] cur_ptr;
	logic [DADDR_W-1:0] src_addr;
	logic dec_add;
	logic dec_sub;
	logic dec_push;
	logic dec_move;
	logic dec_call;
	esiu_state_e state_q;
	logic idle;
	logic [7:0] move_data_q;
	logic move_idx_q;

	// config bit is synchronous core-side logic; register it for timing
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			enabled_q <= 1'b1; // unprogrammed part comes up enabled
		else
			enabled_q <= extended_set_enable_cfg_i;
	end

	// q4_i is not read: decode and capture sit on the cycle edge,
	// which already falls after the core's last phase
	assign op_hi = instr_i[15:8];
	assign fsel = instr_i[7:6];
	assign lit6 = {6'h00, instr_i[5:0]};
	assign cur_ptr = sel_ptr(fsel, fsr0_i, fsr1_i, software_stack_pointer_i);
	assign src_addr = sp_offset(software_stack_pointer_i, instr_i[6:0]);
	assign idle = (state_q == ESIU_IDLE);

	always_comb
	begin
		dec_add = 1'b0;
		dec_sub = 1'b0;
		dec_push = 1'b0;
		dec_move = 1'b0;
		dec_call = 1'b0;
		if (instr_valid_i && idle && enabled_q)
		begin
			dec_add = (op_hi == OP_PTR_ADD);
			dec_sub = (op_hi == OP_PTR_SUB);
			dec_push = (op_hi == OP_PUSH_LIT);
			dec_move = (op_hi == OP_IDX_MOVE);
			dec_call = (instr_i == OP_CALL_WORKING_REGISTER);
		end
	end

	// ==========================================================
	// sequencer
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			state_q <= ESIU_IDLE;
		else
		begin
			unique case (state_q)
				ESIU_IDLE:
				begin
					if ((dec_add || dec_sub) && fsel == SEL_STACK_PTR)
						state_q <= ESIU_RET;
					else if (dec_call)
						state_q <= ESIU_CALL2;
					else if (dec_move)
						state_q <= ESIU_MOVE2;
				end
				ESIU_RET: state_q <= ESIU_IDLE;
				ESIU_CALL2: state_q <= ESIU_IDLE;
				// a missing second word keeps the move pending
				ESIU_MOVE2:
					if (instr_valid_i)
						state_q <= ESIU_IDLE;
			endcase
		end
	end

	// ==========================================================
	// move source capture
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			move_data_q <= 8'h00;
			move_idx_q <= 1'b0;
		end
		else if (dec_move)
		begin
			move_data_q <= is_indirect(src_addr) ? INDIRECT_READ_VALUE
				: mem_rdata_i;
			move_idx_q <= instr_i[7];
		end
	end

	// ==========================================================
	// data memory requests
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			mem_req_o <= '0;
		else
		begin
			mem_req_o <= '0;
			if (dec_push)
			begin
				mem_req_o.wr <= 1'b1;
				mem_req_o.addr <= software_stack_pointer_i;
				mem_req_o.wdata <= instr_i[7:0];
			end
			else if (dec_move)
			begin
				// no indirect access on source
				// an indirect port read would step its pointer, so skip it
				mem_req_o.rd <= !is_indirect(src_addr);
				mem_req_o.addr <= src_addr;
			end
			else if (state_q == ESIU_MOVE2 && instr_valid_i &&
				instr_i[15:12] == OP_SECOND_WORD)
			begin
				mem_req_o.wr <= 1'b1;
				mem_req_o.wdata <= move_data_q;
				mem_req_o.addr <= move_idx_q
					? sp_offset(software_stack_pointer_i, instr_i[6:0])
					: instr_i[11:0];
			end
		end
	end

	// ==========================================================
	// pointer updates; no status flags are ever touched
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			ptr_upd_o <= '0;
		else
		begin
			ptr_upd_o <= '0;
			// select 3 also updates here; return_o is raised separately in the same cycle
			// add or subtract literal
			if (dec_add || dec_sub)
			begin
				ptr_upd_o.wr <= 1'b1;
				ptr_upd_o.sel <= fsel;
				ptr_upd_o.value <= dec_add ? cur_ptr + lit6
					: cur_ptr - lit6;
			end
			else if (dec_push)
			begin
				ptr_upd_o.wr <= 1'b1;
				ptr_upd_o.sel <= SEL_STACK_PTR;
				ptr_upd_o.value <= software_stack_pointer_i - 12'h001;
			end
		end
	end

	// ==========================================================
	// program flow
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			stack_push_o <= 1'b0;
			stack_push_value_o <= '0;
			pc_load_o <= 1'b0;
			pc_value_o <= '0;
			return_o <= 1'b0;
		end
		else
		begin
			stack_push_o <= dec_call;
			stack_push_value_o <= pc_i + PC_RETURN_STEP;
			pc_load_o <= dec_call;
			pc_value_o <= {pc_upper_latch_i[4:0], pc_high_latch_i,
				working_register_i};
			return_o <= (dec_add || dec_sub) && fsel == SEL_STACK_PTR;
		end
	end

	// ==========================================================
	// status to core; a lone second word never hits
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ext_hit_o <= 1'b0;
			busy_o <= 1'b0;
		end
		else
		begin
			// stray second word ignored
			// busy also holds while a move waits for its second word
			ext_hit_o <= dec_add || dec_sub || dec_push || dec_move ||
				dec_call;
			busy_o <= (dec_move || dec_call ||
				((dec_add || dec_sub) && fsel == SEL_STACK_PTR)) ||
				(state_q == ESIU_MOVE2 && !instr_valid_i);
		end
	end

endmodule : esiu_unit

// ### verif/esiu_monitor.sv
// checker for the extended unit ports
// bound onto esiu_unit; enable held steady around each decode
`timescale 1ns/1ps
module esiu_monitor
(
	// clock, reset, inputs
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic extended_set_enable_cfg_i,
	input wire logic instr_valid_i,
	input wire logic [15:0] instr_i,
	input wire logic [7:0] working_register_i,
	input wire logic [7:0] pc_high_latch_i,
	input wire logic [7:0] pc_upper_latch_i,
	input wire logic [esiu_pkg::PC_W-1:0] pc_i,
	input wire logic [esiu_pkg::DADDR_W-1:0] software_stack_pointer_i,
	// outputs watched
	input wire esiu_pkg::esiu_mem_req_s mem_req_o,
	input wire logic pc_load_o,
	input wire logic [esiu_pkg::PC_W-1:0] pc_value_o,
	input wire logic stack_push_o,
	input wire logic [esiu_pkg::PC_W-1:0] stack_push_value_o,
	input wire logic return_o,
	input wire logic ext_hit_o,
	input wire logic busy_o
);
	import esiu_pkg::*;
	// ==========================================================
	// config takes effect one edge late in the unit
	logic en_q;
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			en_q <= 1'b1;
		else
			en_q <= extended_set_enable_cfg_i;
	end
	// decode qualifier; busy cycles refuse fresh words
	wire go = instr_valid_i && !busy_o && extended_set_enable_cfg_i && en_q;
	wire [7:0] op = instr_i[15:8];
	wire [11:0] sp = software_stack_pointer_i;
	wire [11:0] ofs = {5'h00, instr_i[6:0]};
	wire [11:0] src = sp + ofs;
	// indirect ports: three pointers, a span of access ports each
	wire src_ind = ((src - INDF_BASE0) < DADDR_W'(INDF_SPAN)) ||
		((src - INDF_BASE1) < DADDR_W'(INDF_SPAN)) ||
		((src - INDF_BASE2) < DADDR_W'(INDF_SPAN));
	wire [20:0] tgt = {pc_upper_latch_i[4:0], pc_high_latch_i,
		working_register_i};
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// ==========================================================
	// assertions
	push_store_a: assert property (go && op == OP_PUSH_LIT |=>
		mem_req_o.wr && mem_req_o.addr == $past(sp)
		&& mem_req_o.wdata == $past(instr_i[7:0])) else $error("push");
	sub_single_a: assert property (go && op == OP_PTR_SUB
		&& instr_i[7:6] != SEL_STACK_PTR |=> ext_hit_o && !busy_o)
		else $error("sub cycles");
	stack_ret_a: assert property (go && instr_i[7:6] == SEL_STACK_PTR
		&& (op == OP_PTR_ADD || op == OP_PTR_SUB)
		|=> return_o && busy_o ##1 !busy_o) else $error("ret");
	call_target_a: assert property (go && instr_i == OP_CALL_WORKING_REGISTER
		|=> stack_push_o && pc_load_o && pc_value_o == $past(tgt)
		&& stack_push_value_o == $past(pc_i) + PC_RETURN_STEP)
		else $error("call");
	call_nop_a: assert property (go && instr_i == OP_CALL_WORKING_REGISTER
		|=> busy_o ##1 !busy_o && !pc_load_o && !stack_push_o)
		else $error("call nop");
	move_read_a: assert property (go && op == OP_IDX_MOVE
		|=> mem_req_o.rd == !$past(src_ind) && busy_o
		&& mem_req_o.addr == $past(sp) + $past(ofs)) else $error("src");
	move_write_a: assert property (go && op == OP_IDX_MOVE
		&& !instr_i[7] ##1 instr_valid_i
		&& instr_i[15:12] == OP_SECOND_WORD |=> mem_req_o.wr
		&& mem_req_o.addr == $past(instr_i[11:0])) else $error("dst");
	off_ignored_a: assert property (instr_valid_i && !busy_o
		&& !extended_set_enable_cfg_i && !$past(extended_set_enable_cfg_i)
		|=> !ext_hit_o && !mem_req_o.wr) else $error("disabled");
	lone_word_a: assert property (go
		&& instr_i[15:12] == OP_SECOND_WORD
		|=> !ext_hit_o && !mem_req_o.wr) else $error("lone word");
	// main scenarios reached
	cover property (go && instr_i == OP_CALL_WORKING_REGISTER);
	cover property (go && op == OP_IDX_MOVE);
	cover property (go && op == OP_PUSH_LIT);
endmodule : esiu_monitor

bind esiu_unit esiu_monitor i_mon (.clk_sys_i, .rst_i,
	.extended_set_enable_cfg_i, .instr_valid_i, .instr_i,
	.working_register_i, .pc_high_latch_i, .pc_upper_latch_i, .pc_i,
	.software_stack_pointer_i, .mem_req_o, .pc_load_o, .pc_value_o,
	.stack_push_o, .stack_push_value_o, .return_o, .ext_hit_o, .busy_o);

// ### verif/testbench.sv
// testbench for esiu_unit: directed scenario tasks
// assumes outputs show in the cycle after the decoding edge
`timescale 1ns/1ps
module testbench;
	import esiu_pkg::*;
	// ==========================================================
	// stimulus and observed signals
	logic clk_sys_i = 0, rst_i = 1, en = 1, vld = 0;
	logic [15:0] ins = 0;
	logic [7:0] wr = 0, lh = 0, lu = 0, rdat = 0;
	logic [20:0] pc = 0, pcv, spv;
	logic [11:0] f0 = 12'h005, f1 = 12'hffa, sp = 0, e;
	esiu_mem_req_s mq;
	esiu_ptr_upd_s pu;
	logic pl, sps, ret, hit, busy;
	int n_errors = 0, checked = 0;
	// 10 mhz clock
	always #50 clk_sys_i = ~clk_sys_i;
	esiu_unit i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.extended_set_enable_cfg_i(en), .instr_valid_i(vld),
		.instr_i(ins), .q4_i(1'b1), .working_register_i(wr),
		.pc_high_latch_i(lh), .pc_upper_latch_i(lu), .pc_i(pc),
		.fsr0_i(f0), .fsr1_i(f1), .software_stack_pointer_i(sp),
		.mem_rdata_i(rdat), .mem_req_o(mq), .ptr_upd_o(pu),
		.pc_load_o(pl), .pc_value_o(pcv), .stack_push_o(sps),
		.stack_push_value_o(spv), .return_o(ret), .ext_hit_o(hit),
		.busy_o(busy));
	// ==========================================================
	// shared helpers
	task chk(input string s, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[ERR] %s exp %h seen %h", s, exp, seen);
		end
	endtask : chk
	// word held over one decoding edge, stopping at the next falling edge
	task put(input logic [15:0] w);
		vld = 1;
		ins = w;
		@(negedge clk_sys_i);
	endtask : put
	task idle;
		vld = 0;
		@(negedge clk_sys_i);
	endtask : idle
	task results;
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results
	// ==========================================================
	// scenarios
	task t_ptr;
		for (int i = 0; i < 4; i++)
		begin
			put({7'h74, i[1], 1'b0, i[0], 6'h3f});
			e = i[0] ? f1 : f0;
			e = i[1] ? e - 12'h03f : e + 12'h03f;
			chk("ptr", {pu.wr, pu.sel, pu.value, hit, ret, busy}, {2'b10, i[0], e, 3'b100});
		end
		for (int i = 0; i < 2; i++)
		begin
			put({7'h74, i[0], 8'hc2});
			e = i[0] ? sp - 12'h002 : sp + 12'h002;
			chk("ret", {ret, busy, pu.wr, pu.sel, pu.value}, {5'h1f, e});
			idle;
			chk("ret end", {ret, busy, pu.wr}, 3'h0);
		end
	endtask : t_ptr
	task t_push;
		sp = 12'h000;
		put(16'hea55);
		chk("push", {mq.wr, mq.addr, mq.wdata}, {13'h1000, 8'h55});
		chk("dec", {pu.wr, pu.sel, pu.value}, 15'h7fff);
		idle;
	endtask : t_push
	task t_call;
		wr = 8'h06;
		lh = 8'h10;
		lu = 8'hff;
		pc = 21'h1ffffe;
		put(OP_CALL_WORKING_REGISTER);
		chk("push pc", {sps, spv, busy}, 23'h400001);
		chk("load pc", {pl, pcv}, 22'h3f1006);
		idle;
		chk("nop", {pl, sps, busy, mq.wr}, 4'h0);
	endtask : t_call
	// second case lands the source on an indirect port
	task t_move;
		for (int i = 0; i < 3; i++)
		begin
			sp = i == 0 ? 12'hf80 : i == 1 ? 12'hfe0 : 12'h100;
			rdat = 8'h5a;
			put(i == 0 ? 16'heb7f : i == 1 ? 16'heb0b : 16'heb85);
			e = i == 0 ? 12'hfff : i == 1 ? 12'hfeb : 12'h105;
			chk("src", {mq.rd, mq.addr, busy}, {i != 1, e, 1'b1});
			put(i == 0 ? 16'hf000 : i == 1 ? 16'hfffc : 16'hf08a);
			e = i == 0 ? 12'h000 : i == 1 ? 12'hffc : 12'h10a;
			chk("dst", {mq.wr, mq.addr}, {1'b1, e});
			chk("data", mq.wdata, i == 1 ? 8'h00 : 8'h5a);
			idle;
		end
	endtask : t_move
	task t_misc;
		put(16'hf123);
		chk("lone", {hit, mq.wr, mq.rd, busy}, 4'h0);
		en = 0;
		idle;
		put(16'hea55);
		chk("off", {hit, mq.wr}, 2'b00);
		en = 1;
		idle;
		// move waits for its second word, then a foreign word drops it
		put(16'heb05);
		idle;
		chk("wait", {busy, mq.rd, mq.wr}, 3'b100);
		put(16'h1234);
		chk("no pair", {mq.wr, busy}, 2'b00);
		idle;
	endtask : t_misc
	// ==========================================================
	// main sequence and watchdog
	initial
	begin
		repeat (10) @(negedge clk_sys_i);
		rst_i = 0;
		chk("reset", {hit, busy, pl, mq.wr}, 4'h0);
		t_ptr;
		t_push;
		t_call;
		t_move;
		t_misc;
		results;
	end
	initial
	begin
		#100us;
		n_errors++;
		results;
	end
endmodule : testbench
